// *** esr_pkg.sv ***
// Shared constants for the event status and execution fault register block
package esr_pkg;
  localparam int FLAG_W          = 8;
  localparam int REG_W           = 16;
  localparam int CODE_W          = 8;
  localparam int KEY_W           = 8;
  localparam int POWER_UP_BIT    = 7;
  localparam int USER_KEY_BIT    = 6;
  localparam int PARSE_FAULT_BIT = 5;
  localparam int EXEC_FAULT_BIT  = 4;
  localparam int HW_FAULT_BIT    = 3;
  localparam int QUERY_FAULT_BIT = 2;
  localparam int BUS_CTRL_BIT    = 1;
  localparam int OP_DONE_BIT     = 0;
  localparam int SUMMARY_BIT     = 5;
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_MIN  = 8'h15;
  localparam logic [7:0] CODE_MAX  = 8'h40;
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  typedef enum logic [1:0] {
    ESR_IDLE = 2'b00,
    ESR_BUSY = 2'b01
  } esr_exec_t;
endpackage

// *** esr_evt_if.sv ***
// Event strobes passed from the top to the flag register
`timescale 1ns/10ps
interface esr_evt_if;
  logic [7:0] set;
  logic       clr;
  logic [7:0] flags;
  modport src (output set, output clr, input flags);
  modport dst (input set, input clr, output flags);
endinterface

// *** esr_flag_reg.sv ***
// Sticky event flag register with read-and-clear
`timescale 1ns/10ps
module esr_flag_reg (
  input wire logic clk_sys,
  input wire logic rst,
  esr_evt_if.dst   evt
);
  logic [7:0] flags;

  // Set beats clear so no event is lost during a read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags <= esr_pkg::FLAGS_RST;
    end else begin
      flags <= (evt.clr ? esr_pkg::FLAGS_RST : flags) | evt.set;
    end
  end

  assign evt.flags = flags;

  property p_set_survives;
    @(posedge clk_sys) disable iff (rst)
      (evt.clr && evt.set != 8'h00) |=> ((flags & $past(evt.set)) == $past(evt.set));
  endproperty
  a_set_survives: assert property (p_set_survives) else $error("event lost on clear");
endmodule

// *** esr_status_regs.sv ***
// Event status flags, execution fault code and summary bit
`timescale 1ns/10ps
// Function
// - Status read returns flags then clears them
// - Read value is weighted sum bits 0-7
// - Bits above 7 always read zero
// - Power-up sets bit 7
// - Soft key sets bit 6, key recorded
// - Syntax error sets bit 5, code held
// - Execution error sets bit 4, code loaded if in range
// - Hardware fault sets bit 3
// - Empty read or lost output sets bit 2
// - Deadlock or early read sets bit 2
// - Command before response read: flush, bit 2
// - Bus control request bit reads zero
// - Operation-complete command sets bit 0
// - Commands execute strictly one at a time
// - Fault code read returns then clears
// - Fault code keeps most recent in-range error
// - Codes 21 to 64, zero if none
// - Mask selects flags into summary bit
module esr_status_regs (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        user_key_press,
  input  wire logic [7:0]  user_key_id,
  input  wire logic        parse_fault,
  input  wire logic [7:0]  parse_fault_code_in,
  input  wire logic        exec_fault,
  input  wire logic [7:0]  exec_fault_code_in,
  input  wire logic        hw_fault,
  input  wire logic        out_queue_read,
  input  wire logic        out_present,
  input  wire logic        out_lost,
  input  wire logic        in_buf_full,
  input  wire logic        out_buf_full,
  input  wire logic        read_before_end,
  input  wire logic        cmd_start,
  input  wire logic        cmd_done,
  input  wire logic        cmd_is_opc,
  input  wire logic        resp_pending,
  input  wire logic        flags_read,
  input  wire logic        code_read,
  input  wire logic        mask_write,
  input  wire logic [7:0]  mask_wdata,
  output logic      [15:0] event_status_flags,
  output logic      [7:0]  exec_fault_code,
  output logic      [7:0]  user_key_id_register,
  output logic      [7:0]  parse_fault_code,
  output logic      [7:0]  event_summary_mask,
  output logic             event_summary_bit,
  output logic             cmd_accept,
  output logic             out_flush
);
  esr_evt_if evt ();
  esr_pkg::esr_exec_t exec_state;
  logic       power_up_pend;
  logic       opc_seen;
  logic       cmd_go;
  logic [7:0] next_set;

  function automatic logic code_ok(input logic [7:0] c);
    code_ok = (c >= esr_pkg::CODE_MIN) && (c <= esr_pkg::CODE_MAX);
  endfunction

  // Power-up event is raised once after reset release
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_up_pend <= 1'b1;
    end else begin
      power_up_pend <= 1'b0;
    end
  end

  // One command in flight; a new one waits for the last to finish
  assign cmd_accept = (exec_state == esr_pkg::ESR_IDLE);
  assign cmd_go     = cmd_start && cmd_accept;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      exec_state <= esr_pkg::ESR_IDLE;
    end else begin
      unique case (exec_state)
        esr_pkg::ESR_IDLE: begin
          if (cmd_go && !cmd_done) begin
            exec_state <= esr_pkg::ESR_BUSY;
          end
        end
        esr_pkg::ESR_BUSY: begin
          if (cmd_done) begin
            exec_state <= esr_pkg::ESR_IDLE;
          end
        end
        // Unused codes fall back to idle rather than lock the command path
        default: begin
          exec_state <= esr_pkg::ESR_IDLE;
        end
      endcase
    end
  end

  assign opc_seen  = cmd_go && cmd_is_opc;
  assign out_flush = cmd_go && resp_pending;

  always_comb begin
    next_set                              = 8'h00;
    next_set[esr_pkg::POWER_UP_BIT]       = power_up_pend;
    next_set[esr_pkg::USER_KEY_BIT]       = user_key_press;
    next_set[esr_pkg::PARSE_FAULT_BIT]    = parse_fault;
    next_set[esr_pkg::EXEC_FAULT_BIT]     = exec_fault;
    next_set[esr_pkg::HW_FAULT_BIT]       = hw_fault;
    next_set[esr_pkg::QUERY_FAULT_BIT]    = (out_queue_read && !out_present) || out_lost
                                          || (in_buf_full && out_buf_full) || read_before_end
                                          || out_flush;
    next_set[esr_pkg::BUS_CTRL_BIT]       = 1'b0;
    next_set[esr_pkg::OP_DONE_BIT]        = opc_seen;
  end

  assign evt.set = next_set;
  assign evt.clr = flags_read;

  esr_flag_reg u_flags (
    .clk_sys (clk_sys),
    .rst     (rst),
    .evt     (evt)
  );

  // Upper byte is reserved; the lower byte is the weighted sum itself
  assign event_status_flags = {8'h00, evt.flags};

  // Companion registers for key and parser code
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      user_key_id_register <= 8'h00;
    end else if (user_key_press) begin
      user_key_id_register <= user_key_id;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      parse_fault_code <= 8'h00;
    end else if (parse_fault) begin
      parse_fault_code <= parse_fault_code_in;
    end
  end

  // Out-of-range codes are dropped so the register never holds a bad value
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      exec_fault_code <= esr_pkg::CODE_NONE;
    end else if (exec_fault && code_ok(exec_fault_code_in)) begin
      exec_fault_code <= exec_fault_code_in;
    end else if (code_read) begin
      exec_fault_code <= esr_pkg::CODE_NONE;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      event_summary_mask <= esr_pkg::MASK_RST;
    end else if (mask_write) begin
      event_summary_mask <= mask_wdata;
    end
  end

  // Registered so the summary follows the flags by one cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      event_summary_bit <= 1'b0;
    end else begin
      event_summary_bit <= |(evt.flags & event_summary_mask);
    end
  end

  property p_read_clears;
    @(posedge clk_sys) disable iff (rst)
      (flags_read && next_set == 8'h00) |=> (event_status_flags == 16'h0000);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status not cleared");

  property p_upper_zero;
    @(posedge clk_sys) disable iff (rst)
      event_status_flags[15:8] == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("reserved bits set");

  property p_rqc_zero;
    @(posedge clk_sys) disable iff (rst)
      !event_status_flags[esr_pkg::BUS_CTRL_BIT];
  endproperty
  a_rqc_zero: assert property (p_rqc_zero) else $error("bus control bit set");

  property p_hw_sets;
    @(posedge clk_sys) disable iff (rst)
      hw_fault |=> event_status_flags[esr_pkg::HW_FAULT_BIT];
  endproperty
  a_hw_sets: assert property (p_hw_sets) else $error("hw fault flag missed");

  property p_exec_load;
    @(posedge clk_sys) disable iff (rst)
      (exec_fault && code_ok(exec_fault_code_in))
        |=> (exec_fault_code == $past(exec_fault_code_in)) && event_status_flags[esr_pkg::EXEC_FAULT_BIT];
  endproperty
  a_exec_load: assert property (p_exec_load) else $error("exec code not loaded");

  property p_code_range;
    @(posedge clk_sys) disable iff (rst)
      exec_fault_code == esr_pkg::CODE_NONE || code_ok(exec_fault_code);
  endproperty
  a_code_range: assert property (p_code_range) else $error("exec code out of range");

  property p_code_clear;
    @(posedge clk_sys) disable iff (rst)
      (code_read && !exec_fault) |=> exec_fault_code == esr_pkg::CODE_NONE;
  endproperty
  a_code_clear: assert property (p_code_clear) else $error("exec code not cleared");

  property p_flush_qye;
    @(posedge clk_sys) disable iff (rst)
      (cmd_start && cmd_accept && resp_pending) |-> out_flush ##1 event_status_flags[esr_pkg::QUERY_FAULT_BIT];
  endproperty
  a_flush_qye: assert property (p_flush_qye) else $error("flush without query fault");

  property p_in_order;
    @(posedge clk_sys) disable iff (rst)
      (exec_state == esr_pkg::ESR_BUSY && !cmd_done) |=> !cmd_accept;
  endproperty
  a_in_order: assert property (p_in_order) else $error("command overlap");

  property p_summary;
    @(posedge clk_sys) disable iff (rst)
      ##1 event_summary_bit == $past(|(event_status_flags[7:0] & event_summary_mask));
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit wrong");

  property p_pon_sets;
    @(posedge clk_sys) disable iff (rst)
      power_up_pend |=> event_status_flags[esr_pkg::POWER_UP_BIT];
  endproperty
  a_pon_sets: assert property (p_pon_sets) else $error("power-up flag missed");

  property p_key_sets;
    @(posedge clk_sys) disable iff (rst)
      user_key_press |=> event_status_flags[esr_pkg::USER_KEY_BIT] && (user_key_id_register == $past(user_key_id));
  endproperty
  a_key_sets: assert property (p_key_sets) else $error("key flag or id missed");

  property p_key_hold;
    @(posedge clk_sys) disable iff (rst)
      !user_key_press |=> $stable(user_key_id_register);
  endproperty
  a_key_hold: assert property (p_key_hold) else $error("key id changed");

  property p_parse_sets;
    @(posedge clk_sys) disable iff (rst)
      parse_fault |=> event_status_flags[esr_pkg::PARSE_FAULT_BIT] && (parse_fault_code == $past(parse_fault_code_in));
  endproperty
  a_parse_sets: assert property (p_parse_sets) else $error("parse flag or code missed");

  property p_parse_hold;
    @(posedge clk_sys) disable iff (rst)
      !parse_fault |=> $stable(parse_fault_code);
  endproperty
  a_parse_hold: assert property (p_parse_hold) else $error("parse code changed");

  property p_exec_flag;
    @(posedge clk_sys) disable iff (rst)
      exec_fault |=> event_status_flags[esr_pkg::EXEC_FAULT_BIT];
  endproperty
  a_exec_flag: assert property (p_exec_flag) else $error("exec flag missed");

  property p_hw_idle;
    @(posedge clk_sys) disable iff (rst)
      (flags_read && !hw_fault) |=> !event_status_flags[esr_pkg::HW_FAULT_BIT];
  endproperty
  a_hw_idle: assert property (p_hw_idle) else $error("hw flag without fault");

  property p_empty_read;
    @(posedge clk_sys) disable iff (rst)
      (out_queue_read && !out_present) |=> event_status_flags[esr_pkg::QUERY_FAULT_BIT];
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty read not flagged");

  property p_lost;
    @(posedge clk_sys) disable iff (rst)
      out_lost |=> event_status_flags[esr_pkg::QUERY_FAULT_BIT];
  endproperty
  a_lost: assert property (p_lost) else $error("lost output not flagged");

  property p_deadlock;
    @(posedge clk_sys) disable iff (rst)
      (in_buf_full && out_buf_full) |=> event_status_flags[esr_pkg::QUERY_FAULT_BIT];
  endproperty
  a_deadlock: assert property (p_deadlock) else $error("deadlock not flagged");

  property p_early_read;
    @(posedge clk_sys) disable iff (rst)
      read_before_end |=> event_status_flags[esr_pkg::QUERY_FAULT_BIT];
  endproperty
  a_early_read: assert property (p_early_read) else $error("early read not flagged");

  property p_flush_take;
    @(posedge clk_sys) disable iff (rst)
      out_flush |-> (cmd_start && cmd_accept && resp_pending);
  endproperty
  a_flush_take: assert property (p_flush_take) else $error("flush without take");

  property p_opc_sets;
    @(posedge clk_sys) disable iff (rst)
      (cmd_start && cmd_accept && cmd_is_opc) |=> event_status_flags[esr_pkg::OP_DONE_BIT];
  endproperty
  a_opc_sets: assert property (p_opc_sets) else $error("op complete flag missed");

  property p_opc_idle;
    @(posedge clk_sys) disable iff (rst)
      (flags_read && !(cmd_start && cmd_accept && cmd_is_opc)) |=> !event_status_flags[esr_pkg::OP_DONE_BIT];
  endproperty
  a_opc_idle: assert property (p_opc_idle) else $error("op complete flag without command");

  property p_free_after_done;
    @(posedge clk_sys) disable iff (rst)
      (exec_state == esr_pkg::ESR_BUSY && cmd_done) |=> cmd_accept;
  endproperty
  a_free_after_done: assert property (p_free_after_done) else $error("not free after done");

  property p_code_keep;
    @(posedge clk_sys) disable iff (rst)
      (!exec_fault && !code_read) |=> $stable(exec_fault_code);
  endproperty
  a_code_keep: assert property (p_code_keep) else $error("exec code changed");

  property p_mask_load;
    @(posedge clk_sys) disable iff (rst)
      mask_write |=> (event_summary_mask == $past(mask_wdata));
  endproperty
  a_mask_load: assert property (p_mask_load) else $error("mask not loaded");

  property p_hw_beats_clear;
    @(posedge clk_sys) disable iff (rst)
      (flags_read && hw_fault) |=> event_status_flags[esr_pkg::HW_FAULT_BIT];
  endproperty
  a_hw_beats_clear: assert property (p_hw_beats_clear) else $error("fault lost on read");
endmodule

// *** esr_host_model.sv ***
// Remote controller model that issues status and fault code queries
`timescale 1ns/10ps
module esr_host_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        go_flags,
  input  wire logic        go_code,
  input  wire logic [15:0] flags,
  input  wire logic [7:0]  code,
  output logic             flags_read,
  output logic             code_read,
  output logic      [15:0] got_flags,
  output logic      [7:0]  got_code
);
  // Query strobes last one cycle; the answer is what stood before the taking edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags_read <= 1'b0;
      code_read  <= 1'b0;
      got_flags  <= 16'h0000;
      got_code   <= 8'h00;
    end else begin
      flags_read <= go_flags;
      code_read  <= go_code;
      if (flags_read) got_flags <= flags;
      if (code_read) got_code <= code;
    end
  end
endmodule

// *** event_status_and_exec_error_regs_tb_top.sv ***
// Self-checking testbench for the status and fault code registers
`timescale 1ns/10ps
module event_status_and_exec_error_regs_tb_top;
  logic        clk_sys, rst, out_present, cmd_start, cmd_done, cmd_is_opc, resp_pending, mask_write;
  logic        flags_read, code_read, go_flags, go_code, event_summary_bit, cmd_accept, out_flush, in_full;
  logic [7:0]  ev, user_key_id, parse_fault_code_in, exec_fault_code_in, mask_wdata, exec_fault_code;
  logic [7:0]  user_key_id_register, parse_fault_code, event_summary_mask, got_code;
  logic [15:0] event_status_flags, got_flags;
  int          failures, n_tests;
  // Both buffers full is the only deadlock stimulus, so one strobe drives both
  assign in_full = ev[7];
  esr_status_regs esr_status_regs_inst (.clk_sys(clk_sys), .rst(rst), .user_key_press(ev[0]),
    .user_key_id(user_key_id), .parse_fault(ev[1]), .parse_fault_code_in(parse_fault_code_in),
    .exec_fault(ev[2]), .exec_fault_code_in(exec_fault_code_in), .hw_fault(ev[3]), .out_queue_read(ev[4]),
    .out_present(out_present), .out_lost(ev[5]), .in_buf_full(in_full), .out_buf_full(in_full),
    .read_before_end(ev[6]), .cmd_start(cmd_start), .cmd_done(cmd_done), .cmd_is_opc(cmd_is_opc),
    .resp_pending(resp_pending), .flags_read(flags_read), .code_read(code_read), .mask_write(mask_write),
    .mask_wdata(mask_wdata), .event_status_flags(event_status_flags), .exec_fault_code(exec_fault_code),
    .user_key_id_register(user_key_id_register), .parse_fault_code(parse_fault_code),
    .event_summary_mask(event_summary_mask), .event_summary_bit(event_summary_bit),
    .cmd_accept(cmd_accept), .out_flush(out_flush));
  esr_host_model esr_host_model_inst (.clk_sys(clk_sys), .rst(rst), .go_flags(go_flags), .go_code(go_code),
    .flags(event_status_flags), .code(exec_fault_code), .flags_read(flags_read), .code_read(code_read),
    .got_flags(got_flags), .got_code(got_code));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task tick;
    @(posedge clk_sys);
    #1;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rd_flags(input logic [15:0] e);
    go_flags = 1'b1;
    tick;
    go_flags = 1'b0;
    tick;
    chk("flags answer", e, got_flags);
    chk("flags cleared", 16'h0000, event_status_flags);
  endtask
  task rd_code(input logic [7:0] e);
    go_code = 1'b1;
    tick;
    go_code = 1'b0;
    tick;
    chk("code answer", {8'h00, e}, {8'h00, got_code});
    chk("code cleared", 16'h0000, {8'h00, exec_fault_code});
  endtask
  task strobe(input logic [7:0] v);
    ev = v;
    tick;
    ev = 8'h00;
  endtask
  task t_power_up;
    chk("power flags", 16'h0080, event_status_flags);
    chk("code idle", 16'h0000, {8'h00, exec_fault_code});
    chk("accept idle", 16'h0001, {15'h0000, cmd_accept});
    rd_flags(16'h0080);
  endtask
  task t_events;
    logic [7:0] w [8];
    w = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h04, 8'h04, 8'h04};
    for (int i = 0; i < 8; i++) begin
      strobe(8'h01 << i);
      chk("event flag", {8'h00, w[i]}, event_status_flags);
      rd_flags({8'h00, w[i]});
    end
    out_present = 1'b1;
    strobe(8'h10);
    chk("present read", 16'h0000, event_status_flags);
    out_present = 1'b0;
    chk("key id", 16'h003C, {8'h00, user_key_id_register});
    chk("parse code", 16'h005A, {8'h00, parse_fault_code});
    chk("exec code", 16'h0015, {8'h00, exec_fault_code});
  endtask
  task t_code;
    exec_fault_code_in = 8'h40;
    strobe(8'h04);
    chk("newest code", 16'h0040, {8'h00, exec_fault_code});
    exec_fault_code_in = 8'h41;
    strobe(8'h04);
    chk("out of range code", 16'h0040, {8'h00, exec_fault_code});
    rd_code(8'h40);
    go_code = 1'b1;
    tick;
    go_code = 1'b0;
    exec_fault_code_in = 8'h16;
    strobe(8'h04);
    chk("fault beats clear", 16'h0016, {8'h00, exec_fault_code});
    rd_flags(16'h0010);
  endtask
  task t_atomic;
    go_flags = 1'b1;
    tick;
    go_flags = 1'b0;
    strobe(8'h08);
    chk("event kept", 16'h0008, event_status_flags);
    rd_flags(16'h0008);
  endtask
  task t_cmd;
    {resp_pending, cmd_is_opc, cmd_start} = 3'b111;
    #1;
    chk("flush", 16'h0001, {15'h0000, out_flush});
    tick;
    {resp_pending, cmd_is_opc} = 2'b00;
    chk("busy", 16'h0000, {15'h0000, cmd_accept});
    chk("opc and query", 16'h0005, event_status_flags);
    tick;
    chk("still busy", 16'h0000, {15'h0000, cmd_accept});
    cmd_done = 1'b1;
    tick;
    cmd_done = 1'b0;
    chk("free again", 16'h0001, {15'h0000, cmd_accept});
    tick;
    cmd_start = 1'b0;
    chk("second taken", 16'h0000, {15'h0000, cmd_accept});
    cmd_done = 1'b1;
    tick;
    cmd_done = 1'b0;
    rd_flags(16'h0005);
  endtask
  task t_mask;
    mask_wdata = 8'h08;
    mask_write = 1'b1;
    tick;
    mask_write = 1'b0;
    chk("mask", 16'h0008, {8'h00, event_summary_mask});
    strobe(8'h02);
    tick;
    chk("masked off", 16'h0000, {15'h0000, event_summary_bit});
    strobe(8'h08);
    tick;
    chk("summary", 16'h0001, {15'h0000, event_summary_bit});
    rd_flags(16'h0028);
  endtask
  task wrap_up;
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run is about 60 cycles; the limit leaves wide margin
  initial begin
    #100000;
    failures++;
    wrap_up;
  end
  initial begin
    {rst, out_present, cmd_start, cmd_done, cmd_is_opc, resp_pending, mask_write, go_flags, go_code} = 9'h100;
    {ev, mask_wdata, user_key_id, parse_fault_code_in, exec_fault_code_in} = {24'h00003C, 16'h5A15};
    failures = 0;
    n_tests = 0;
    repeat (5) @(posedge clk_sys);
    #1 rst = 1'b0;
    tick;
    tick;
    t_power_up;
    t_events;
    t_code;
    t_atomic;
    t_cmd;
    t_mask;
    wrap_up;
  end
endmodule
